// ### pkg/sci_regs.vh
// register map, field positions, reset values and timing counts of the serial block
`ifndef SCI_REGS_VH
`define SCI_REGS_VH
`define SCI_IDX_STATUS 8'hf0
`define SCI_IDX_DATA 8'hf1
`define SCI_IDX_BAUD 8'hf2
`define SCI_IDX_LINE 8'hf3
`define SCI_IDX_RX_FINE 8'hf5
`define SCI_IDX_TX_FINE 8'hf6
`define SCI_IDX_LIN 8'hff
`define SCI_BAUD_PRE_HI 7
`define SCI_BAUD_PRE_LO 6
`define SCI_BAUD_TX_HI 5
`define SCI_BAUD_TX_LO 3
`define SCI_BAUD_RX_HI 2
`define SCI_BAUD_RX_LO 0
`define SCI_LINE_SEND_BREAK 0
`define SCI_LINE_TX_EN 1
`define SCI_LINE_RX_EN 2
`define SCI_LINE_NINE_BIT 4
`define SCI_LINE_TX_BIT8 5
`define SCI_LIN_ENABLE 6
`define SCI_ST_TX_EMPTY 0
`define SCI_ST_TX_BUSY 1
`define SCI_ST_RX_FULL 2
`define SCI_ST_OVERRUN 3
`define SCI_ST_RX_BIT8 4
`define SCI_ST_FRAME_ERR 5
`define SCI_RST_BAUD 8'h00
`define SCI_RST_LINE 8'h00
`define SCI_RST_FINE 8'h00
`define SCI_RST_LIN 8'h00
`define SCI_PRE_TC0 4'h0
`define SCI_PRE_TC1 4'h2
`define SCI_PRE_TC2 4'h3
`define SCI_PRE_TC3 4'hc
`define SCI_OVERSAMPLE 5'h10
`define SCI_MID_SAMPLE 4'h7
`define SCI_BRK_BASE 4'ha
`endif

// ### rtl/sci_baud_lin.v
// serial interface: apb registers, baud generator, transmitter with lin break, receiver
// Functional notes
// RQ1 - with lin enable set, send break emits synch breaks of thirteen low bit times; the code sends fourteen when nine-bit words are also set.
// RQ2 - break low length is 10, 11 with nine-bit words, 13 with lin, 14 with both.
// RQ3 - data address writes the transmit holding register and reads the receive holding register.
// RQ4 - first prescaler divides the bus clock by 1, 3, 4 or 13 for codes 0 to 3.
// RQ5 - transmit divisor field divides by two to the field value, 1 to 128.
// RQ6 - receive divisor field divides by two to the field value, 1 to 128.
// RQ7 - transmit divisor alone applies while extended transmit value is zero, else the product.
// RQ8 - receive divisor alone applies while extended receive value is zero, else the product.
// RQ9 - nonzero extended receive value further divides the rate by 1 to 255.
// RQ10 - nonzero extended transmit value further divides the rate by 1 to 255.
// RQ11 - both extended prescalers reset to zero so only the plain path sets rates.
// RQ12 - setting then clearing send break sends one break after the current word; set while idle, the code breaks at once and the clear queues a second.
// RQ13 - word length bit selects eight or nine data bits between one start and one stop bit.
// RQ14 - rate settings take effect only while no character is in progress, without glitches.
`include "sci_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module sci_baud_lin
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rxd,
  output reg txd,
  output reg txd_oe
);
  localparam TX_IDLE = 2'd0;
  localparam TX_FRAME = 2'd1;
  localparam TX_BREAK = 2'd2;
  localparam TX_STOP = 2'd3;
  localparam RX_IDLE = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_DATA = 2'd2;
  localparam RX_STOP = 2'd3;

  reg [7:0] baud_rate_select_q;
  reg [7:0] line_control_q;
  reg [7:0] rx_extended_prescaler_q;
  reg [7:0] tx_extended_prescaler_q;
  reg [7:0] lin_control_q;
  reg [7:0] tx_holding_register_q;
  reg tx_empty_q;
  reg [8:0] rx_holding_register_q;
  reg rx_full_q;
  reg overrun_q;
  reg frame_err_q;
  reg break_pend_q;
  reg [1:0] sh_pre_q;
  reg [5:0] sh_div_q;
  reg [15:0] sh_ext_q;
  reg [3:0] pre_cnt_q;
  reg [1:0] tx_state_q;
  reg [3:0] tx_os_q;
  reg [3:0] tx_bits_q;
  reg [10:0] tx_shift_q;
  reg [1:0] rx_state_q;
  reg [3:0] rx_os_q;
  reg [3:0] rx_bits_q;
  reg [8:0] rx_shift_q;
  reg rxd_meta_q;
  reg rxd_sync_q;
  reg rxd_prev_q;

  wire [1:0] rate_tick;
  wire [7:0] idx = paddr[9:2];
  wire aligned = (paddr[1:0] == 2'b00);
  wire wr_en = psel & penable & pready & pwrite & aligned;
  wire rd_en = psel & penable & pready & ~pwrite & aligned;
  wire nine_bit = line_control_q[`SCI_LINE_NINE_BIT];
  wire lin_en = lin_control_q[`SCI_LIN_ENABLE];
  wire send_break = line_control_q[`SCI_LINE_SEND_BREAK];
  wire tx_en = line_control_q[`SCI_LINE_TX_EN];
  wire rx_en = line_control_q[`SCI_LINE_RX_EN];
  wire tx_idle = (tx_state_q == TX_IDLE);
  wire rx_idle = (rx_state_q == RX_IDLE);
  wire data_wr = wr_en & (idx == `SCI_IDX_DATA);
  wire data_rd = rd_en & (idx == `SCI_IDX_DATA);
  wire line_wr = wr_en & (idx == `SCI_IDX_LINE);
  wire tx_bit_end = rate_tick[0] & (tx_os_q == 4'hf);
  wire break_req = send_break | break_pend_q;
  wire [3:0] brk_len;
  wire [3:0] pre_tc;
  reg mapped;
  reg [7:0] rd_val;

  // break length: base ten, plus one for nine-bit words, plus three for lin
  assign brk_len = `SCI_BRK_BASE + {2'b00, lin_en, lin_en} + {3'b000, nine_bit}; // [RQ1] [RQ2]
  assign pre_tc = (sh_pre_q == 2'd0) ? `SCI_PRE_TC0 :
                  (sh_pre_q == 2'd1) ? `SCI_PRE_TC1 :
                  (sh_pre_q == 2'd2) ? `SCI_PRE_TC2 : `SCI_PRE_TC3; // [RQ4]
  wire pre_tick = (pre_cnt_q == pre_tc);

  // apb read mux and decode
  always @*
  begin
    mapped = 1'b1;
    rd_val = 8'h00;
    if (idx == `SCI_IDX_STATUS)
    begin
      rd_val = {2'b00, frame_err_q, rx_holding_register_q[8], overrun_q, rx_full_q,
                ~tx_idle, tx_empty_q};
    end
    else if (idx == `SCI_IDX_DATA)
    begin
      rd_val = rx_holding_register_q[7:0]; // [RQ3]
    end
    else if (idx == `SCI_IDX_BAUD)
    begin
      rd_val = baud_rate_select_q;
    end
    else if (idx == `SCI_IDX_LINE)
    begin
      rd_val = line_control_q;
    end
    else if (idx == `SCI_IDX_RX_FINE)
    begin
      rd_val = rx_extended_prescaler_q;
    end
    else if (idx == `SCI_IDX_TX_FINE)
    begin
      rd_val = tx_extended_prescaler_q;
    end
    else if (idx == `SCI_IDX_LIN)
    begin
      rd_val = lin_control_q & 8'h40;
    end
    else
    begin
      mapped = 1'b0;
    end
  end

  // one wait-free access phase; answer prepared during setup
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~(mapped & aligned);
      prdata <= (psel & ~penable & ~pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end
  end

  // software registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      baud_rate_select_q <= `SCI_RST_BAUD;
      line_control_q <= `SCI_RST_LINE;
      rx_extended_prescaler_q <= `SCI_RST_FINE; // [RQ11]
      tx_extended_prescaler_q <= `SCI_RST_FINE; // [RQ11]
      lin_control_q <= `SCI_RST_LIN;
      tx_holding_register_q <= 8'h00;
    end
    else if (wr_en)
    begin
      if (idx == `SCI_IDX_BAUD)
        baud_rate_select_q <= pwdata[7:0];
      else if (idx == `SCI_IDX_LINE)
        line_control_q <= pwdata[7:0];
      else if (idx == `SCI_IDX_RX_FINE)
        rx_extended_prescaler_q <= pwdata[7:0];
      else if (idx == `SCI_IDX_TX_FINE)
        tx_extended_prescaler_q <= pwdata[7:0];
      else if (idx == `SCI_IDX_LIN)
        lin_control_q <= pwdata[7:0] & 8'h40;
      else if (idx == `SCI_IDX_DATA)
        tx_holding_register_q <= pwdata[7:0]; // [RQ3]
    end
  end

  // shadows move only between characters so a rate change never cuts a bit short
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh_pre_q <= 2'd0;
      sh_div_q <= 6'd0;
      sh_ext_q <= 16'h0000;
      pre_cnt_q <= 4'h0;
    end
    else
    begin
      if (tx_idle & rx_idle)
      begin
        sh_pre_q <= baud_rate_select_q[`SCI_BAUD_PRE_HI:`SCI_BAUD_PRE_LO]; // [RQ14]
        sh_div_q <= {baud_rate_select_q[`SCI_BAUD_RX_HI:`SCI_BAUD_RX_LO],
                     baud_rate_select_q[`SCI_BAUD_TX_HI:`SCI_BAUD_TX_LO]}; // [RQ14]
        sh_ext_q <= {rx_extended_prescaler_q, tx_extended_prescaler_q}; // [RQ14]
      end
      pre_cnt_q <= pre_tick ? 4'h0 : pre_cnt_q + 4'h1; // [RQ4]
    end
  end

  // per-channel rate chain: divisor by 2^n, then optional extended divide; ch0 tx, ch1 rx
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_rate
      reg [6:0] div_cnt_q;
      reg [7:0] ext_cnt_q;
      wire [2:0] div_sel = sh_div_q[ch*3 +: 3];
      wire [7:0] ext_val = sh_ext_q[ch*8 +: 8];
      wire [6:0] div_tc = (7'h01 << div_sel) - 7'h01;
      wire div_tick = pre_tick & (div_cnt_q == div_tc);
      // zero extended value bypasses the stage
      wire ext_last = (ext_val == 8'h00) | (ext_cnt_q == ext_val - 8'h01); // [RQ7] [RQ8]
      assign rate_tick[ch] = div_tick & ext_last;
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          div_cnt_q <= 7'h00;
          ext_cnt_q <= 8'h00;
        end
        else if (pre_tick)
        begin
          div_cnt_q <= div_tick ? 7'h00 : div_cnt_q + 7'h01; // [RQ5] [RQ6]
          if (div_tick)
            ext_cnt_q <= ext_last ? 8'h00 : ext_cnt_q + 8'h01; // [RQ9] [RQ10]
        end
      end
    end
  endgenerate

  // transmitter; a break queued by set-then-clear waits for the frame end
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state_q <= TX_IDLE;
      tx_os_q <= 4'h0;
      tx_bits_q <= 4'h0;
      tx_shift_q <= 11'h7ff;
      tx_empty_q <= 1'b1;
      break_pend_q <= 1'b0;
      txd <= 1'b1;
      txd_oe <= 1'b0;
    end
    else
    begin
      txd_oe <= tx_en;
      if (line_wr & send_break & ~pwdata[`SCI_LINE_SEND_BREAK])
        break_pend_q <= 1'b1; // [RQ12]
      else if (tx_idle & tx_en & break_req & rate_tick[0])
        break_pend_q <= 1'b0;
      if (data_wr)
        tx_empty_q <= 1'b0;
      case (tx_state_q)
        TX_IDLE:
        begin
          txd <= 1'b1;
          tx_os_q <= 4'h0;
          // starts aligned to a rate tick so the first bit is full length
          if (tx_en & rate_tick[0] & break_req)
          begin
            tx_state_q <= TX_BREAK;
            tx_bits_q <= brk_len; // [RQ1] [RQ2]
            txd <= 1'b0;
          end
          else if (tx_en & rate_tick[0] & ~tx_empty_q & ~data_wr)
          begin
            tx_state_q <= TX_FRAME;
            // holding word moves to the shifter, so software may reload at once
            tx_empty_q <= 1'b1;
            // start, 8 or 9 data, stop, lsb first
            tx_shift_q <= nine_bit ?
              {1'b1, line_control_q[`SCI_LINE_TX_BIT8], tx_holding_register_q, 1'b0} :
              {2'b11, tx_holding_register_q, 1'b0}; // [RQ13]
            tx_bits_q <= nine_bit ? 4'hb : 4'ha; // [RQ13]
            txd <= 1'b0;
          end
        end
        TX_FRAME:
        begin
          if (rate_tick[0])
            tx_os_q <= tx_os_q + 4'h1;
          if (tx_bit_end)
          begin
            tx_shift_q <= {1'b1, tx_shift_q[10:1]};
            txd <= tx_shift_q[1];
            tx_bits_q <= tx_bits_q - 4'h1;
            if (tx_bits_q == 4'h1)
            begin
              tx_state_q <= TX_IDLE;
              txd <= 1'b1;
            end
          end
        end
        TX_BREAK:
        begin
          if (rate_tick[0])
            tx_os_q <= tx_os_q + 4'h1;
          if (tx_bit_end)
          begin
            tx_bits_q <= tx_bits_q - 4'h1;
            if (tx_bits_q == 4'h1)
            begin
              tx_state_q <= TX_STOP;
              txd <= 1'b1;
            end
          end
        end
        default:
        begin
          if (rate_tick[0])
            tx_os_q <= tx_os_q + 4'h1;
          if (tx_bit_end)
            tx_state_q <= TX_IDLE;
        end
      endcase
    end
  end

  // receive pin synchroniser
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxd_meta_q <= 1'b1;
      rxd_sync_q <= 1'b1;
      rxd_prev_q <= 1'b1;
    end
    else
    begin
      rxd_meta_q <= rxd;
      rxd_sync_q <= rxd_meta_q;
      rxd_prev_q <= rxd_sync_q;
    end
  end

  // receiver, samples at mid bit on the 16x rate tick
  wire rx_mid = rate_tick[1] & (rx_os_q == `SCI_MID_SAMPLE);
  wire rx_done = (rx_state_q == RX_STOP) & rx_mid;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state_q <= RX_IDLE;
      rx_os_q <= 4'h0;
      rx_bits_q <= 4'h0;
      rx_shift_q <= 9'h000;
      rx_holding_register_q <= 9'h000;
      rx_full_q <= 1'b0;
      overrun_q <= 1'b0;
      frame_err_q <= 1'b0;
    end
    else
    begin
      if (rate_tick[1])
        rx_os_q <= rx_os_q + 4'h1;
      case (rx_state_q)
        RX_IDLE:
        begin
          rx_os_q <= 4'h0;
          if (rx_en & rxd_prev_q & ~rxd_sync_q)
            rx_state_q <= RX_START;
        end
        RX_START:
        begin
          if (rx_mid)
          begin
            rx_state_q <= rxd_sync_q ? RX_IDLE : RX_DATA;
            rx_bits_q <= nine_bit ? 4'h9 : 4'h8; // [RQ13]
          end
        end
        RX_DATA:
        begin
          if (rx_mid)
          begin
            rx_shift_q <= nine_bit ? {rxd_sync_q, rx_shift_q[8:1]} :
                                     {1'b0, rxd_sync_q, rx_shift_q[7:1]};
            rx_bits_q <= rx_bits_q - 4'h1;
            if (rx_bits_q == 4'h1)
              rx_state_q <= RX_STOP;
          end
        end
        default:
        begin
          if (rx_mid)
            rx_state_q <= RX_IDLE;
        end
      endcase
      // a word landing in the read cycle clears overrun and keeps rx full set
      if (rx_done & rx_full_q & ~data_rd)
        overrun_q <= 1'b1;
      else if (data_rd | ~rx_en)
        overrun_q <= 1'b0;
      if (rx_done & (~rx_full_q | data_rd))
      begin
        rx_holding_register_q <= rx_shift_q; // [RQ3]
        rx_full_q <= 1'b1;
        frame_err_q <= ~rxd_sync_q;
      end
      else if (data_rd | ~rx_en)
      begin
        rx_full_q <= 1'b0;
        frame_err_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/sci_chk.sv
// apb and serial pin checks of the serial block
`timescale 1ns/1ns
`default_nettype none
module sci_chk
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire rxd,
  input wire txd,
  input wire txd_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_data_quiet: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  a_data_upper: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_data_mapped: assert property (psel && !penable && paddr == 10'h3c4 |=> !pslverr)
    else $error("error on data register");
  a_err_unmapped: assert property (psel && !penable && paddr == 10'h040 |=> pslverr)
    else $error("no error on unmapped address");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  // shortest bit time is sixteen clocks
  a_low_min: assert property ($fell(txd) |=> !txd [*8])
    else $error("low bit too short");
  a_high_min: assert property ($rose(txd) |=> txd [*8])
    else $error("high bit too short");
endmodule
bind sci_baud_lin sci_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .txd_oe(txd_oe));
`default_nettype wire

// ### testbench/sci_node.sv
// remote serial node: measures low runs on txd, sends frames on rxd
`timescale 1ns/1ns
`default_nettype none
module sci_node
(
  input wire logic pclk,
  input wire logic txd,
  input wire logic txd_oe,
  output logic rxd
);
  int low_cnt = 0;
  int last_low = 0;
  int runs = 0;
  initial rxd = 1'b1;
  always @(posedge pclk)
  begin
    if (txd_oe === 1'b1 && txd === 1'b0)
      low_cnt <= low_cnt + 1;
    else if (low_cnt != 0)
    begin
      last_low <= low_cnt;
      runs <= runs + 1;
      low_cnt <= 0;
    end
  end
  // start, lsb first, stop; line rests high like a pulled-up bus
  task automatic send(input logic [7:0] b, input int bt);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd <= f[i];
      repeat (bt) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
// testbench of the serial block: registers, bit times, breaks and receive
`include "sci_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, txd_oe;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] rd;
  logic err;
  int fail_count = 0;
  int compares = 0;
  int r0;
  logic [7:0] bv [6] = '{8'h00, 8'h40, 8'h80, 8'hc0, 8'h18, 8'h08};
  logic [7:0] ev [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
  int bt [6] = '{16, 48, 64, 208, 128, 96};
  int blen [4] = '{10, 11, 13, 14};
  sci_baud_lin i_sci_baud_lin (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .txd_oe(txd_oe));
  sci_node node (.pclk(pclk), .txd(txd), .txd_oe(txd_oe), .rxd(rxd));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // values read right after the edge are those the edge sampled
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_runs(input int n);
    int k;
    k = 0;
    while (node.runs < n && k < 20000)
    begin
      @(posedge pclk);
      k++;
    end
    if (node.runs < n)
      fail_count++;
  endtask
  task automatic conclude;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #500000;
    fail_count++;
    conclude;
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `SCI_IDX_RX_FINE, 8'h00);
    chk("rx fine reset", rd, 8'h00);
    apb(0, `SCI_IDX_TX_FINE, 8'h00);
    chk("tx fine reset", rd, 8'h00);
    apb(0, `SCI_IDX_LIN, 8'h00);
    chk("lin reset", rd, 8'h00);
    apb(1, `SCI_IDX_RX_FINE, 8'ha5);
    apb(0, `SCI_IDX_RX_FINE, 8'h00);
    chk("rx fine", rd, 8'ha5);
    apb(1, `SCI_IDX_TX_FINE, 8'h5a);
    apb(0, `SCI_IDX_TX_FINE, 8'h00);
    chk("tx fine", rd, 8'h5a);
    apb(1, `SCI_IDX_LIN, 8'hff);
    apb(0, `SCI_IDX_LIN, 8'h00);
    chk("lin", rd, 8'h40);
    apb(0, 8'h10, 8'h00);
    chk("unmapped", {err, rd}, 9'h100);
    apb(1, `SCI_IDX_RX_FINE, 8'h00);
    apb(1, `SCI_IDX_LIN, 8'h00);
    apb(1, `SCI_IDX_LINE, 8'h02);
    for (int i = 0; i < 6; i++)
    begin
      apb(1, `SCI_IDX_BAUD, bv[i]);
      apb(1, `SCI_IDX_TX_FINE, ev[i]);
      r0 = node.runs;
      apb(1, `SCI_IDX_DATA, 8'hff);
      wait_runs(r0 + 1);
      chk("bit time", node.last_low, bt[i]);
      repeat (bt[i] * 2) @(posedge pclk);
    end
    apb(1, `SCI_IDX_TX_FINE, 8'h00);
    apb(1, `SCI_IDX_BAUD, 8'h00);
    apb(1, `SCI_IDX_LINE, 8'h12);
    r0 = node.runs;
    apb(1, `SCI_IDX_DATA, 8'hff);
    wait_runs(r0 + 2);
    chk("ninth bit", node.last_low, 16);
    repeat (64) @(posedge pclk);
    // set then clear: one break now, one queued behind it
    for (int k = 0; k < 4; k++)
    begin
      apb(1, `SCI_IDX_LIN, k[1] ? 8'h40 : 8'h00);
      apb(1, `SCI_IDX_LINE, k[0] ? 8'h13 : 8'h03);
      r0 = node.runs;
      apb(1, `SCI_IDX_LINE, k[0] ? 8'h12 : 8'h02);
      wait_runs(r0 + 1);
      chk("break", node.last_low, blen[k] * 16);
      repeat (600) @(posedge pclk);
      chk("break count", node.runs - r0, 2);
    end
    apb(1, `SCI_IDX_LIN, 8'h00);
    apb(1, `SCI_IDX_BAUD, 8'h01);
    apb(1, `SCI_IDX_RX_FINE, 8'h02);
    apb(1, `SCI_IDX_LINE, 8'h06);
    node.send(8'h5a, 64);
    repeat (64) @(posedge pclk);
    apb(0, `SCI_IDX_STATUS, 8'h00);
    chk("rx full", rd[`SCI_ST_RX_FULL], 1'b1);
    chk("tx empty", rd[`SCI_ST_TX_EMPTY], 1'b1);
    apb(0, `SCI_IDX_DATA, 8'h00);
    chk("rx data", rd, 8'h5a);
    apb(0, `SCI_IDX_STATUS, 8'h00);
    chk("rx drained", rd[`SCI_ST_RX_FULL], 1'b0);
    conclude;
  end
endmodule
`default_nettype wire
